// ---- shared/wtl_pkg.sv ----
/*
 * Package for the wakeup timer and voltage-detect control block:
 * register offsets, field positions, reset values, period tables and
 * the packed structs that carry the bus channels.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package wtl_pkg;
	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [3:0] WTL_OFS_TIMER = 4'h0; // Wakeup timer status/control
	localparam logic [3:0] WTL_OFS_POWER = 4'h4; // Power monitor status/control
	localparam logic [3:0] WTL_OFS_IRQ_STAT = 4'h8; // Sticky event status
	localparam logic [3:0] WTL_OFS_IRQ_MASK = 4'hC; // Interrupt mask

	// ****************************************************************
	// Timer register fields
	// ****************************************************************
	localparam int WTL_T_FLAG = 7; // Timeout flag
	localparam int WTL_T_ACK = 6; // Acknowledge, write-only
	localparam int WTL_T_CLKSEL = 5; // Clock select
	localparam int WTL_T_IRQEN = 4; // Interrupt enable
	localparam int WTL_T_PSEL_HI = 2; // Period select top bit

	// ****************************************************************
	// Power register fields
	// ****************************************************************
	localparam int WTL_P_FLAG = 7; // Detect flag
	localparam int WTL_P_ACK = 6; // Acknowledge, write-only
	localparam int WTL_P_IRQEN = 5; // Interrupt enable
	localparam int WTL_P_RSTEN = 4; // Reset enable, write-once
	localparam int WTL_P_STOPEN = 3; // Stop-mode enable
	localparam int WTL_P_DETEN = 2; // Detect enable, write-once
	localparam int WTL_P_BANDGAP_BUFFER_ENABLE = 0; // Bandgap buffer enable

	// ****************************************************************
	// Interrupt status and mask bit positions
	// ****************************************************************
	localparam int WTL_I_TIMER = 0; // Wakeup timeout event
	localparam int WTL_I_DETECT = 1; // Voltage-detect event

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] WTL_RST_TIMER = 8'h00;
	localparam logic [7:0] WTL_RST_POWER = 8'h1C;
	localparam logic [1:0] WTL_RST_MASK = 2'h0;

	// ****************************************************************
	// Timing: source clocks are sampled on mclk
	// ****************************************************************
	localparam int WTL_CNT_W = 16; // Widest period counter
	localparam int WTL_PSEL_W = 3; // Period select width
	localparam logic [1:0] WTL_RESP_OKAY = 2'h0;
	localparam logic [1:0] WTL_RESP_SLVERR = 2'h2;

	// Period in source clock ticks, minus one, for the 1 kHz source
	function automatic logic [WTL_CNT_W-1:0] wtl_period_lo(input logic [2:0] sel);
		case (sel)
			3'h1: wtl_period_lo = 16'h0007; // 8 ticks
			3'h2: wtl_period_lo = 16'h001F; // 32 ticks
			3'h3: wtl_period_lo = 16'h003F; // 64 ticks
			3'h4: wtl_period_lo = 16'h007F; // 128 ticks
			3'h5: wtl_period_lo = 16'h00FF; // 256 ticks
			3'h6: wtl_period_lo = 16'h01FF; // 512 ticks
			3'h7: wtl_period_lo = 16'h03FF; // 1024 ticks
			default: wtl_period_lo = 16'h0000;
		endcase
	endfunction

	// Period in source clock ticks, minus one, for the 32 kHz source
	function automatic logic [WTL_CNT_W-1:0] wtl_period_hi(input logic [2:0] sel);
		case (sel)
			3'h1: wtl_period_hi = 16'h00FF; // 256 ticks
			3'h2: wtl_period_hi = 16'h03FF; // 1024 ticks
			3'h3: wtl_period_hi = 16'h07FF; // 2048 ticks
			3'h4: wtl_period_hi = 16'h0FFF; // 4096 ticks
			3'h5: wtl_period_hi = 16'h1FFF; // 8192 ticks
			3'h6: wtl_period_hi = 16'h3FFF; // 16384 ticks
			3'h7: wtl_period_hi = 16'h7FFF; // 32768 ticks
			default: wtl_period_hi = 16'h0000;
		endcase
	endfunction

	// ****************************************************************
	// Bus carriers
	// ****************************************************************
	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} wtl_wreq_t;

	typedef struct packed {
		logic [31:0] data;
		logic [1:0] resp;
	} wtl_rsp_t;
endpackage

// ---- design/wtl_sync.sv ----
/*
 * Two-flop synchroniser for asynchronous single-bit levels.
 * Assumes the input is a slow level or a clock much slower than mclk.
 */
`timescale 1ns/10ps
module wtl_sync (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic din,
	output logic dout
);
	logic meta_reg; // First stage, read only by the second
	logic meta_next;
	logic dout_next;

	// ****************************************************************
	// Next values
	// ****************************************************************
	always_comb begin
		meta_next = din;
		dout_next = meta_reg;
	end

	// Register both stages
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			meta_reg <= 1'b0;
			dout <= 1'b0;
		end else begin
			meta_reg <= meta_next;
			dout <= dout_next;
		end
	end
endmodule

// ---- design/wtl_period_timer.sv ----
/*
 * Periodic wakeup counter. Counts rising edges of the selected,
 * already synchronised source clock and pulses at the end of the period.
 * Assumes both source clocks arrive synchronised to mclk.
 */
`timescale 1ns/10ps
module wtl_period_timer (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic clk_lo_sync,
	input wire logic clk_hi_sync,
	input wire logic clock_select,
	input wire logic [2:0] period_select,
	output logic timeout
);
	logic lo_prev_reg; // Last seen level of the 1 kHz source
	logic hi_prev_reg; // Last seen level of the 32 kHz source
	logic [wtl_pkg::WTL_CNT_W-1:0] count_reg;
	logic [wtl_pkg::WTL_CNT_W-1:0] count_next;
	logic [3:0] cfg_reg; // Previous configuration, for restart
	logic timeout_next;
	logic tick;
	logic [wtl_pkg::WTL_CNT_W-1:0] limit;

	// ****************************************************************
	// Counter next state
	// ****************************************************************
	always_comb begin
		tick = clock_select ? (clk_hi_sync & ~hi_prev_reg) : (clk_lo_sync & ~lo_prev_reg);
		limit = clock_select ? wtl_pkg::wtl_period_hi(period_select) : wtl_pkg::wtl_period_lo(period_select);
		count_next = count_reg;
		timeout_next = 1'b0;
		if (period_select == 3'h0 || cfg_reg != {clock_select, period_select}) begin
			count_next = '0; // Restart on disable or reconfigure; free tick phase
		end else if (tick) begin
			if (count_reg >= limit) begin
				count_next = '0; // Period end
				timeout_next = 1'b1;
			end else begin
				count_next = count_reg + 16'h0001;
			end
		end
	end

	// Register counter state
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			lo_prev_reg <= 1'b0;
			hi_prev_reg <= 1'b0;
			count_reg <= '0;
			cfg_reg <= 4'h0;
			timeout <= 1'b0;
		end else begin
			lo_prev_reg <= clk_lo_sync;
			hi_prev_reg <= clk_hi_sync;
			count_reg <= count_next;
			cfg_reg <= {clock_select, period_select};
			timeout <= timeout_next;
		end
	end
endmodule

// ---- design/wtl_sysctl.sv ----
/*
 * Wakeup timer and voltage-detect system control register bank with an
 * AXI4-Lite slave, sticky interrupt status with mask, and control outputs.
 * Assumes the two source clocks and the analog detect level are
 * asynchronous to mclk and much slower than it.
 */
`timescale 1ns/10ps
module wtl_sysctl (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic clk_1khz,
	input wire logic clk_32khz,
	input wire logic detect_in,
	input wire logic stop_mode,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq,
	output logic wakeup_irq_req,
	output logic voltage_detect_irq_req,
	output logic system_reset_req,
	output logic bandgap_buffer_enable
);
	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic lo_sync; // 1 kHz source in mclk domain
	logic hi_sync; // 32 kHz source in mclk domain
	logic det_sync; // Detect level in mclk domain
	logic timeout; // One-cycle timeout pulse
	logic det_prev_reg; // Detect level last cycle
	logic [7:0] timer_reg; // Timer register; bits 7,5,4,2:0 stored
	logic [7:0] timer_next;
	logic [7:0] power_reg; // Power register; bits 7,5,4,3,2,0 stored
	logic [7:0] power_next;
	logic rsten_done_reg; // Reset-enable bit already written
	logic rsten_done_next;
	logic deten_done_reg; // Detect-enable bit already written
	logic deten_done_next;
	logic [1:0] stat_reg; // Sticky event status
	logic [1:0] stat_next;
	logic [1:0] mask_reg; // Interrupt mask
	logic [1:0] mask_next;
	logic aw_held_reg; // Write address taken
	logic aw_held_next;
	logic w_held_reg; // Write data taken
	logic w_held_next;
	wtl_pkg::wtl_wreq_t wreq_reg; // Captured write request
	wtl_pkg::wtl_wreq_t wreq_next;
	logic bvalid_next;
	logic [1:0] bresp_next;
	wtl_pkg::wtl_rsp_t rsp_next; // Read answer
	logic rvalid_next;
	logic awready_next;
	logic wready_next;
	logic arready_next;
	logic do_write; // Both halves held, write now
	logic det_event; // Qualified detect rising edge
	logic irq_next;
	logic wk_req_next;
	logic vd_req_next;
	logic rst_req_next;
	logic bg_next;

	// ****************************************************************
	// Synchronisers and period timer
	// ****************************************************************
	// Asynchronous inputs pass two flops
	wtl_sync u_sync_lo (.mclk(mclk), .resetn(resetn), .din(clk_1khz), .dout(lo_sync));
	wtl_sync u_sync_hi (.mclk(mclk), .resetn(resetn), .din(clk_32khz), .dout(hi_sync));
	wtl_sync u_sync_det (.mclk(mclk), .resetn(resetn), .din(detect_in), .dout(det_sync));

	// Counter of rising edges of the chosen source, clocked by mclk
	wtl_period_timer u_timer (
		.mclk(mclk),
		.resetn(resetn),
		.clk_lo_sync(lo_sync),
		.clk_hi_sync(hi_sync),
		.clock_select(timer_reg[wtl_pkg::WTL_T_CLKSEL]),
		.period_select(timer_reg[wtl_pkg::WTL_T_PSEL_HI:0]),
		.timeout(timeout)
	);

	// ****************************************************************
	// AXI4-Lite write and read channels
	// ****************************************************************
	always_comb begin
		aw_held_next = aw_held_reg;
		w_held_next = w_held_reg;
		wreq_next = wreq_reg;
		bvalid_next = s_axi_bvalid;
		bresp_next = s_axi_bresp;
		// Address and data are taken independently
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_next = 1'b1;
			wreq_next.addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_next = 1'b1;
			wreq_next.data = s_axi_wdata;
			wreq_next.strb = s_axi_wstrb;
		end
		do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
		if (do_write) begin
			aw_held_next = 1'b0;
			w_held_next = 1'b0;
			bvalid_next = 1'b1;
			case (wreq_reg.addr)
				wtl_pkg::WTL_OFS_TIMER, wtl_pkg::WTL_OFS_POWER,
				wtl_pkg::WTL_OFS_IRQ_STAT, wtl_pkg::WTL_OFS_IRQ_MASK: begin
					bresp_next = wtl_pkg::WTL_RESP_OKAY;
				end
				default: begin
					bresp_next = wtl_pkg::WTL_RESP_SLVERR; // Unmapped
				end
			endcase
		end else if (s_axi_bvalid && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		awready_next = !aw_held_next && !bvalid_next;
		wready_next = !w_held_next && !bvalid_next;
		// Read channel
		rsp_next.data = s_axi_rdata;
		rsp_next.resp = s_axi_rresp;
		rvalid_next = s_axi_rvalid;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_next = 1'b1;
			rsp_next.resp = wtl_pkg::WTL_RESP_OKAY;
			case (s_axi_araddr)
				// Acknowledge bits always read zero
				wtl_pkg::WTL_OFS_TIMER: begin
					rsp_next.data = {24'h000000, timer_reg & 8'hB7};
				end
				wtl_pkg::WTL_OFS_POWER: begin
					rsp_next.data = {24'h000000, power_reg & 8'hBD};
				end
				wtl_pkg::WTL_OFS_IRQ_STAT: begin
					rsp_next.data = {30'h00000000, stat_reg};
				end
				wtl_pkg::WTL_OFS_IRQ_MASK: begin
					rsp_next.data = {30'h00000000, mask_reg};
				end
				default: begin
					rsp_next.data = 32'h00000000;
					rsp_next.resp = wtl_pkg::WTL_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
		arready_next = !rvalid_next;
	end

	// ****************************************************************
	// Register bank and event flags
	// ****************************************************************
	always_comb begin
		timer_next = timer_reg;
		power_next = power_reg;
		rsten_done_next = rsten_done_reg;
		deten_done_next = deten_done_reg;
		stat_next = stat_reg;
		mask_next = mask_reg;
		// Detection runs when enabled, and in stop only if allowed
		det_event = det_sync && !det_prev_reg && power_reg[wtl_pkg::WTL_P_DETEN]
			&& (!stop_mode || power_reg[wtl_pkg::WTL_P_STOPEN]);
		// Software writes, low byte lane only
		if (do_write && wreq_reg.strb[0]) begin
			case (wreq_reg.addr)
				wtl_pkg::WTL_OFS_TIMER: begin
					timer_next[wtl_pkg::WTL_T_CLKSEL] = wreq_reg.data[wtl_pkg::WTL_T_CLKSEL];
					timer_next[wtl_pkg::WTL_T_IRQEN] = wreq_reg.data[wtl_pkg::WTL_T_IRQEN];
					timer_next[wtl_pkg::WTL_T_PSEL_HI:0] = wreq_reg.data[wtl_pkg::WTL_T_PSEL_HI:0];
					if (wreq_reg.data[wtl_pkg::WTL_T_ACK]) begin
						timer_next[wtl_pkg::WTL_T_FLAG] = 1'b0; // Acknowledge
					end
				end
				wtl_pkg::WTL_OFS_POWER: begin
					power_next[wtl_pkg::WTL_P_IRQEN] = wreq_reg.data[wtl_pkg::WTL_P_IRQEN];
					power_next[wtl_pkg::WTL_P_STOPEN] = wreq_reg.data[wtl_pkg::WTL_P_STOPEN];
					power_next[wtl_pkg::WTL_P_BANDGAP_BUFFER_ENABLE] = wreq_reg.data[wtl_pkg::WTL_P_BANDGAP_BUFFER_ENABLE];
					// Write-once bits lock after the first write
					if (!rsten_done_reg) begin
						power_next[wtl_pkg::WTL_P_RSTEN] = wreq_reg.data[wtl_pkg::WTL_P_RSTEN];
						rsten_done_next = 1'b1;
					end
					if (!deten_done_reg) begin
						power_next[wtl_pkg::WTL_P_DETEN] = wreq_reg.data[wtl_pkg::WTL_P_DETEN];
						deten_done_next = 1'b1;
					end
					if (wreq_reg.data[wtl_pkg::WTL_P_ACK]) begin
						power_next[wtl_pkg::WTL_P_FLAG] = 1'b0; // Acknowledge
					end
				end
				wtl_pkg::WTL_OFS_IRQ_STAT: begin
					stat_next = stat_reg & ~wreq_reg.data[1:0]; // Write one to clear
				end
				wtl_pkg::WTL_OFS_IRQ_MASK: begin
					mask_next = wreq_reg.data[1:0];
				end
				default: begin
					mask_next = mask_reg;
				end
			endcase
		end
		// Hardware sets win over clears in the same cycle
		if (timeout) begin
			timer_next[wtl_pkg::WTL_T_FLAG] = 1'b1;
			stat_next[wtl_pkg::WTL_I_TIMER] = 1'b1;
		end
		if (det_event) begin
			power_next[wtl_pkg::WTL_P_FLAG] = 1'b1;
			stat_next[wtl_pkg::WTL_I_DETECT] = 1'b1;
		end
		// Request outputs follow the next register values
		wk_req_next = timer_next[wtl_pkg::WTL_T_FLAG] && timer_next[wtl_pkg::WTL_T_IRQEN];
		vd_req_next = power_next[wtl_pkg::WTL_P_FLAG] && power_next[wtl_pkg::WTL_P_IRQEN];
		rst_req_next = power_next[wtl_pkg::WTL_P_FLAG] && power_next[wtl_pkg::WTL_P_RSTEN]
			&& power_next[wtl_pkg::WTL_P_DETEN];
		bg_next = power_next[wtl_pkg::WTL_P_BANDGAP_BUFFER_ENABLE];
		irq_next = |(stat_next & mask_next);
	end

	// Register all state and outputs
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			timer_reg <= wtl_pkg::WTL_RST_TIMER;
			power_reg <= wtl_pkg::WTL_RST_POWER;
			rsten_done_reg <= 1'b0;
			deten_done_reg <= 1'b0;
			stat_reg <= 2'h0;
			mask_reg <= wtl_pkg::WTL_RST_MASK;
			det_prev_reg <= 1'b0;
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			wreq_reg <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
			irq <= 1'b0;
			wakeup_irq_req <= 1'b0;
			voltage_detect_irq_req <= 1'b0;
			system_reset_req <= 1'b0;
			bandgap_buffer_enable <= 1'b0;
		end else begin
			timer_reg <= timer_next;
			power_reg <= power_next;
			rsten_done_reg <= rsten_done_next;
			deten_done_reg <= deten_done_next;
			stat_reg <= stat_next;
			mask_reg <= mask_next;
			det_prev_reg <= det_sync;
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			wreq_reg <= wreq_next;
			s_axi_awready <= awready_next;
			s_axi_wready <= wready_next;
			s_axi_bvalid <= bvalid_next;
			s_axi_bresp <= bresp_next;
			s_axi_arready <= arready_next;
			s_axi_rvalid <= rvalid_next;
			s_axi_rdata <= rsp_next.data;
			s_axi_rresp <= rsp_next.resp;
			irq <= irq_next;
			wakeup_irq_req <= wk_req_next;
			voltage_detect_irq_req <= vd_req_next;
			system_reset_req <= rst_req_next;
			bandgap_buffer_enable <= bg_next;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_timer_flag_set: assert property (@(posedge mclk) disable iff (!resetn)
		timeout |=> timer_reg[wtl_pkg::WTL_T_FLAG]) else $error("timeout did not set flag");
	a_timer_ack_clr: assert property (@(posedge mclk) disable iff (!resetn)
		(do_write && wreq_reg.strb[0] && wreq_reg.addr == wtl_pkg::WTL_OFS_TIMER
		&& wreq_reg.data[wtl_pkg::WTL_T_ACK] && !timeout) |=> !timer_reg[wtl_pkg::WTL_T_FLAG])
		else $error("timer ack did not clear flag");
	a_timer_req_gate: assert property (@(posedge mclk) disable iff (!resetn)
		wakeup_irq_req |-> (timer_reg[wtl_pkg::WTL_T_FLAG] && timer_reg[wtl_pkg::WTL_T_IRQEN]))
		else $error("timer request without flag and enable");
	a_timer_off_quiet: assert property (@(posedge mclk) disable iff (!resetn)
		(timer_reg[2:0] == 3'h0) [*3] |-> !timeout) else $error("disabled timer timed out");
	a_detect_gated: assert property (@(posedge mclk) disable iff (!resetn)
		(!power_reg[wtl_pkg::WTL_P_DETEN] && !power_reg[wtl_pkg::WTL_P_FLAG])
		|=> !power_reg[wtl_pkg::WTL_P_FLAG]) else $error("detect flag set while disabled");
	a_detect_req_gate: assert property (@(posedge mclk) disable iff (!resetn)
		voltage_detect_irq_req |-> (power_reg[wtl_pkg::WTL_P_FLAG] && power_reg[wtl_pkg::WTL_P_IRQEN]))
		else $error("detect request without flag and enable");
	a_reset_force: assert property (@(posedge mclk) disable iff (!resetn)
		system_reset_req == (power_reg[wtl_pkg::WTL_P_FLAG] && power_reg[wtl_pkg::WTL_P_RSTEN]
		&& power_reg[wtl_pkg::WTL_P_DETEN])) else $error("system reset request mismatch");
	a_bandgap_follow: assert property (@(posedge mclk) disable iff (!resetn)
		bandgap_buffer_enable == power_reg[wtl_pkg::WTL_P_BANDGAP_BUFFER_ENABLE]) else $error("bandgap enable mismatch");
	a_once_locked: assert property (@(posedge mclk) disable iff (!resetn)
		deten_done_reg |=> $stable(power_reg[wtl_pkg::WTL_P_DETEN])) else $error("write-once bit changed");
	a_stop_blocks: assert property (@(posedge mclk) disable iff (!resetn)
		(stop_mode && !power_reg[wtl_pkg::WTL_P_STOPEN]) |-> !det_event) else $error("detect in stop");
	c_timeout: cover property (@(posedge mclk) disable iff (!resetn) timeout);
	c_detect: cover property (@(posedge mclk) disable iff (!resetn) det_event);
	c_irq: cover property (@(posedge mclk) disable iff (!resetn) irq);
	c_reset_req: cover property (@(posedge mclk) disable iff (!resetn) system_reset_req);
endmodule

// ---- verification/testbench.sv ----
/*
 * Self-checking testbench for wtl_sysctl: AXI4-Lite register access,
 * timer periods, voltage-detect flags, write-once bits and interrupts.
 * Assumes the wtl package and the design modules are compiled first.
 */
`timescale 1ns/10ps
module testbench;
	// ****************************************************************
	// Signals
	// ****************************************************************
	logic mclk = 0, resetn = 0, clk_1khz = 0, clk_32khz = 0, detect_in = 0, stop_mode = 0;
	logic [3:0] awaddr = 0, araddr = 0, src_cnt = 0, strb = 4'hF;
	logic [31:0] wdata = 0, rd_data, rdata, rnd;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, irq, wk_req, vd_req, rst_req, bg_en;
	logic [1:0] bresp, rresp;
	int num_errors = 0, total_checks = 0, seed = 61, n;

	// Bus clock, 20 ns
	always #10 mclk = ~mclk;
	// Source clocks: slow source 16 mclk periods, fast source 8
	always @(posedge mclk) begin
		src_cnt <= src_cnt + 4'h1;
		clk_1khz <= src_cnt[3];
		clk_32khz <= src_cnt[2];
	end

	wtl_sysctl dut (.mclk(mclk), .resetn(resetn), .clk_1khz(clk_1khz), .clk_32khz(clk_32khz),
		.detect_in(detect_in), .stop_mode(stop_mode), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq),
		.wakeup_irq_req(wk_req), .voltage_detect_irq_req(vd_req), .system_reset_req(rst_req),
		.bandgap_buffer_enable(bg_en));

	// ****************************************************************
	// Tasks
	// ****************************************************************
	// Compare and count
	task check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Expected response: only word-aligned offsets are mapped
	function automatic logic [1:0] exp_resp(input logic [3:0] a);
		return (a[1:0] == 2'b00) ? wtl_pkg::WTL_RESP_OKAY : wtl_pkg::WTL_RESP_SLVERR;
	endfunction

	// AXI4-Lite write; address and data released separately when taken
	task wr(input logic [3:0] a, input logic [31:0] d);
		logic aw_p, w_p;
		logic [1:0] resp;
		int k;
		aw_p = 1;
		w_p = 1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge mclk);
			if (aw_p && awready) begin
				aw_p = 0;
				awvalid <= 1'b0;
			end
			if (w_p && wready) begin
				w_p = 0;
				wvalid <= 1'b0;
			end
			if (bvalid) begin
				resp = bresp;
				break;
			end
		end
		bready <= 1'b0;
		check(k < 50, 1);
		check(resp, exp_resp(a));
		@(posedge mclk);
	endtask

	// AXI4-Lite read
	task rd(input logic [3:0] a, output logic [31:0] d);
		logic [1:0] resp;
		int k;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge mclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				resp = rresp;
				break;
			end
		end
		rready <= 1'b0;
		check(k < 50, 1);
		check(resp, exp_resp(a));
		@(posedge mclk);
	endtask

	// Read and compare
	task rchk(input logic [3:0] a, input logic [31:0] exp);
		rd(a, rd_data);
		check(rd_data, exp);
	endtask

	// Expected period in source ticks
	function automatic int ticks(input logic cs, input int ps);
		int base;
		base = cs ? 256 : 8;
		return (ps == 1) ? base : base << ps;
	endfunction

	// Restart timer, time the first timeout, then acknowledge it
	task tmeas(input logic cs, input logic [2:0] ps, input int per);
		int t;
		t = ticks(cs, ps);
		wr(4'h0, 32'h40);
		wr(4'h0, {26'h0, cs, 1'b1, 1'b0, ps});
		for (n = 0; n < 40000 && wk_req !== 1'b1; n++) @(posedge mclk);
		check(n >= (t - 1) * per - 20 && n <= t * per + 16, 1);
		rchk(4'h0, {24'h0, 2'b10, cs, 1'b1, 1'b0, ps});
		wr(4'h0, {25'h0, 1'b1, cs, 2'b00, ps});
		rchk(4'h0, {26'h0, cs, 2'b00, ps});
		check(wk_req, 0);
	endtask

	// Counts and verdict, the single end of the run
	task give_verdict;
		$display("Checks %0d, errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Watchdog well beyond the expected run
	initial begin
		#1600000;
		num_errors++;
		give_verdict;
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		repeat (5) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		rchk(4'h0, 0);
		rchk(4'h4, 32'h1C);
		rchk(4'hC, 0);
		// Detect with reset defaults: reset enable and detect enable on
		detect_in <= 1'b1;
		repeat (10) @(posedge mclk);
		check({rst_req, vd_req}, 2'b10);
		rchk(4'h4, 32'h9C);
		// First power write acknowledges the flag and locks the write-once bits
		wr(4'h4, 32'h6D);
		rchk(4'h4, 32'h2D);
		check({rst_req, bg_en}, 2'b01);
		wr(4'h4, 32'h10);
		rchk(4'h4, 32'h04);
		check(bg_en, 0);
		wr(4'h4, 32'h2C);
		wr(4'hC, 32'h2);
		wr(4'h8, 32'h3);
		detect_in <= 1'b0;
		repeat (10) @(posedge mclk);
		detect_in <= 1'b1;
		repeat (10) @(posedge mclk);
		check({vd_req, rst_req, irq}, 3'b101);
		rchk(4'h8, 32'h2);
		wr(4'h8, 32'h2);
		check(irq, 0);
		wr(4'h4, 32'h6C);
		check(vd_req, 0);
		// Stop mode with stop enable off blocks detection
		stop_mode <= 1'b1;
		wr(4'h4, 32'h24);
		detect_in <= 1'b0;
		repeat (10) @(posedge mclk);
		detect_in <= 1'b1;
		repeat (10) @(posedge mclk);
		rchk(4'h4, 32'h24);
		stop_mode <= 1'b0;
		// Random mask values
		repeat (4) begin
			rnd = $random(seed);
			wr(4'hC, rnd);
			rchk(4'hC, {30'h0, rnd[1:0]});
		end
		// Without byte lane 0 a write is ignored; an unmapped offset answers an error
		strb <= 4'hE;
		wr(4'hC, 32'h0);
		strb <= 4'hF;
		rchk(4'hC, {30'h0, rnd[1:0]});
		wr(4'h2, 32'hFF);
		rchk(4'h2, 0);
		// Timer periods on both sources
		for (int p = 1; p < 8; p++) tmeas(1'b0, p[2:0], 16);
		for (int p = 1; p < 4; p++) tmeas(1'b1, p[2:0], 8);
		// Period select zero keeps the timer quiet
		wr(4'h0, 32'h50);
		repeat (2100) @(posedge mclk);
		check(wk_req, 0);
		rchk(4'h0, 32'h10);
		// Sticky timer status drives irq through the mask
		wr(4'hC, 32'h1);
		check(irq, 1);
		wr(4'h8, 32'h1);
		check(irq, 0);
		// Mid-run reset: the first power write turns detection off for good
		detect_in <= 1'b0;
		resetn <= 1'b0;
		repeat (5) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		rchk(4'h8, 0);
		wr(4'h4, 32'h30);
		wr(4'h4, 32'h34);
		detect_in <= 1'b1;
		repeat (10) @(posedge mclk);
		rchk(4'h4, 32'h30);
		check({rst_req, vd_req, irq}, 3'b000);
		give_verdict;
	end
endmodule
